// File: hdl/pic_pkg.sv
package pic_pkg;
  // source indices, highest priority first
  localparam int unsigned NUM_SRC      = 6;
  localparam int unsigned SRC_EXT_HIGH = 5;
  localparam int unsigned SRC_SERIAL   = 4;
  localparam int unsigned SRC_TMR1     = 3;
  localparam int unsigned SRC_TMR2     = 2;
  localparam int unsigned SRC_TICK     = 1;
  localparam int unsigned SRC_EXT_LOW  = 0;
  // mask field positions
  localparam int unsigned MASK_SERIAL  = 3;
  localparam int unsigned MASK_TMR1    = 2;
  localparam int unsigned MASK_SHARED  = 1;
  localparam int unsigned MASK_EXT_LOW = 0;
  // reset values
  localparam logic [3:0]  MASK_RST     = 4'h0;
  localparam logic [5:0]  LATCH_RST    = 6'h00;
  localparam logic        MIE_RST      = 1'b0;
  // vectors: highest source first, even addresses
  localparam logic [11:0] VEC_BASE     = 12'h002;
  localparam logic [11:0] VEC_STEP     = 12'h002;
  // acknowledge length in instruction cycles
  localparam int unsigned ACK_CYCLES   = 2;

  typedef enum logic [1:0] {
    PIC_IDLE,
    PIC_ACK1,
    PIC_ACK2
  } pic_state_t;
endpackage : pic_pkg

// File: hdl/pic_if.sv
`timescale 1ns/1ns
`default_nettype none
// carries the request vector between edge capture and controller
interface pic_req_if;
  logic [5:0] req;
  modport src (output req);
  modport dst (input req);
endinterface : pic_req_if
`default_nettype wire

// File: hdl/pic_edge.sv
`timescale 1ns/1ns
`default_nettype none
// falling edge detect for the two external pins
module pic_edge (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rstn,
  // pins
  input  wire logic pin_in,
  // event
  output logic      fall
);
  import pic_pkg::*;

  typedef struct packed {
    logic prev;
  } pic_edge_st_t;

  pic_edge_st_t st_ff;
  pic_edge_st_t nxt_st;

  // track previous level, idle high
  always_comb begin
    nxt_st      = st_ff;
    nxt_st.prev = pin_in;
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st_ff <= '{prev: 1'b1};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // R19 falling edge detect
  assign fall = st_ff.prev & ~pin_in;

  // R19 falling edge flagged
  property p_fall;
    @(posedge sys_clk) disable iff (!rstn)
      ($past(pin_in) && !pin_in) |-> fall;
  endproperty
  a_fall: assert property (p_fall) else $error("missed pin fall"); // R19
endmodule : pic_edge
`default_nettype wire

// File: hdl/pic_req.sv
`timescale 1ns/1ns
`default_nettype none
// gathers the six request events into one vector
module pic_req (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rstn,
  // sources
  input  wire logic ext_irq_high,
  input  wire logic ext_irq_low,
  input  wire logic serial_irq,
  input  wire logic timer_one_overflow_irq,
  input  wire logic timer_two_overflow_irq,
  input  wire logic interval_tick_irq,
  // out
  pic_req_if.src    rq
);
  import pic_pkg::*;

  logic [1:0] ext_pins;
  logic [1:0] ext_fall;

  assign ext_pins = {ext_irq_high, ext_irq_low};

  // R19 pin edge capture
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_pin
      pic_edge u_edge (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .pin_in  (ext_pins[g]),
        .fall    (ext_fall[g])
      );
    end
  endgenerate

  // internal sources are one-cycle pulses
  assign rq.req = {ext_fall[1], serial_irq, timer_one_overflow_irq,
                   timer_two_overflow_irq, interval_tick_irq, ext_fall[0]};
endmodule : pic_req
`default_nettype wire

// File: hdl/pic_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// R1 - six sources, each with pending latch
// R2 - fixed priority, high pin first
// R3 - even vectors 002 to 00c
// R4 - master enable gates all acceptance
// R5 - accept clears, return sets master enable
// R6 - software sets/clears master; resets zero
// R7 - four bit mask, high pin unmaskable
// R8 - mask bit 1 enables two sources
// R9 - mask accessed by swap; resets zero
// R10 - accepted latch cleared; all reset zero
// R11 - clear field: 0 clears, 1 holds
// R12 - instructions never set latches
// R13 - request held until accept or clear
// R14 - acknowledge takes two instruction cycles
// R15 - push, vector, flag, disable, clear
// R16 - return restores context, enables master
// R17 - only pc and flags saved
// R18 - nesting handled by service software
// R19 - pin latches set on falling edge
// R20 - request beats simultaneous clear
module pic_ctrl (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  // request sources
  input  wire logic        ext_irq_high,
  input  wire logic        ext_irq_low,
  input  wire logic        serial_irq,
  input  wire logic        timer_one_overflow_irq,
  input  wire logic        timer_two_overflow_irq,
  input  wire logic        interval_tick_irq,
  // sequencer: instruction boundary and ops
  input  wire logic        instr_end,
  input  wire logic        cycle_end,
  input  wire logic        enable_and_clear_latches,
  input  wire logic        disable_and_clear_latches,
  input  wire logic        clear_latches_only,
  input  wire logic [5:0]  latch_field,
  input  wire logic        swap_with_accumulator,
  input  wire logic [3:0]  acc_in,
  input  wire logic        return_from_irq,
  // sequencer answers
  output logic             irq_pending,
  output logic             ack_busy,
  output logic             push_ctx,
  output logic             restore_ctx,
  output logic             load_pc,
  output logic [11:0]      pc_vector,
  output logic             set_status_flag,
  output logic [3:0]       acc_out,
  // visible state
  output logic             master_irq_enable,
  output logic [3:0]       source_enable_mask,
  output logic [5:0]       pending_latch
);
  import pic_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    pic_state_t  state;
    logic        mie;
    logic [3:0]  mask;
    logic [5:0]  latch;
    logic [2:0]  sel;
    logic [11:0] vec;
    logic        push;
    logic        ld;
    logic        sf;
    logic        rst_ctx;
    logic [3:0]  acc;
  } pic_st_t;

  pic_st_t st_ff;
  pic_st_t nxt_st;

  pic_req_if rq ();

  ////////////////////////////////////////////////////////////////////////////
  // request capture
  pic_req u_req (
    .sys_clk                (sys_clk),
    .rstn                   (rstn),
    .ext_irq_high           (ext_irq_high),
    .ext_irq_low            (ext_irq_low),
    .serial_irq             (serial_irq),
    .timer_one_overflow_irq (timer_one_overflow_irq),
    .timer_two_overflow_irq (timer_two_overflow_irq),
    .interval_tick_irq      (interval_tick_irq),
    .rq                     (rq.src)
  );

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  // per-source enable from the mask
  function automatic logic [5:0] src_enable(input logic [3:0] m);
    logic [5:0] e;
    e = 6'h00;
    // R7 high pin always allowed
    e[SRC_EXT_HIGH] = 1'b1;
    e[SRC_SERIAL]   = m[MASK_SERIAL];
    e[SRC_TMR1]     = m[MASK_TMR1];
    // R8 shared mask bit
    e[SRC_TMR2]     = m[MASK_SHARED];
    e[SRC_TICK]     = m[MASK_SHARED];
    e[SRC_EXT_LOW]  = m[MASK_EXT_LOW];
    return e;
  endfunction : src_enable

  // R2 highest index wins
  function automatic logic [2:0] pick(input logic [5:0] r);
    logic [2:0] s;
    s = 3'h0;
    for (int i = 0; i < NUM_SRC; i++) begin
      if (r[i]) begin
        s = 3'(i);
      end
    end
    return s;
  endfunction : pick

  // R3 vector from source index
  function automatic logic [11:0] vec_of(input logic [2:0] s);
    logic [2:0] rank;
    rank = 3'(SRC_EXT_HIGH) - s;
    return VEC_BASE + 12'(VEC_STEP * {9'h000, rank});
  endfunction : vec_of

  logic [5:0] eligible;
  logic       take;
  logic       sw_clear;

  // R4 master gates, mask qualifies
  assign eligible = st_ff.latch & src_enable(st_ff.mask)
                  & {NUM_SRC{st_ff.mie}};
  // R14 accept only at instruction end
  assign take     = (st_ff.state == PIC_IDLE) && instr_end
                  && (|eligible) && !return_from_irq;
  assign sw_clear = enable_and_clear_latches | disable_and_clear_latches
                  | clear_latches_only;

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    nxt_st         = st_ff;
    nxt_st.push    = 1'b0;
    nxt_st.ld      = 1'b0;
    nxt_st.sf      = 1'b0;
    nxt_st.rst_ctx = 1'b0;

    // R11 zero field bit clears
    if (sw_clear) begin
      nxt_st.latch = nxt_st.latch & latch_field;
    end

    // R6 software master control
    if (enable_and_clear_latches) begin
      nxt_st.mie = 1'b1;
    end else if (disable_and_clear_latches) begin
      nxt_st.mie = 1'b0;
    end

    // R9 swap mask with accumulator
    if (swap_with_accumulator) begin
      nxt_st.acc  = st_ff.mask;
      nxt_st.mask = acc_in;
    end

    // R16 return restores and enables
    if (return_from_irq && st_ff.state == PIC_IDLE) begin
      nxt_st.rst_ctx = 1'b1;
      nxt_st.mie     = 1'b1;
    end

    case (st_ff.state)
      PIC_IDLE: begin
        if (take) begin
          // R15 push context first
          nxt_st.sel   = pick(eligible);
          nxt_st.push  = 1'b1;
          nxt_st.state = PIC_ACK1;
        end
      end
      PIC_ACK1: begin
        if (cycle_end) begin
          // R15 vector, flag, disable, clear
          nxt_st.vec   = vec_of(st_ff.sel);
          nxt_st.ld    = 1'b1;
          nxt_st.sf    = 1'b1;
          // R5 accept clears master
          nxt_st.mie   = 1'b0;
          // R10 accepted latch cleared
          nxt_st.latch[st_ff.sel] = 1'b0;
          nxt_st.state = PIC_ACK2;
        end
      end
      PIC_ACK2: begin
        // R14 second cycle ends acknowledge
        if (cycle_end) begin
          nxt_st.state = PIC_IDLE;
        end
      end
      default: begin
        nxt_st.state = PIC_IDLE;
      end
    endcase

    // R1 R12 R13 R20 only requests set, set wins
    nxt_st.latch = nxt_st.latch | rq.req;
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      // R6 R9 R10 reset values
      st_ff <= '{state: PIC_IDLE, mie: MIE_RST, mask: MASK_RST,
                 latch: LATCH_RST, sel: 3'h0, vec: 12'h000, push: 1'b0,
                 ld: 1'b0, sf: 1'b0, rst_ctx: 1'b0, acc: 4'h0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  // R17 only pc and flags pushed
  assign push_ctx           = st_ff.push;
  assign restore_ctx        = st_ff.rst_ctx;
  assign load_pc            = st_ff.ld;
  assign pc_vector          = st_ff.vec;
  assign set_status_flag    = st_ff.sf;
  assign acc_out            = st_ff.acc;
  assign irq_pending        = |eligible;
  assign ack_busy           = st_ff.state != PIC_IDLE;
  assign master_irq_enable  = st_ff.mie;
  assign source_enable_mask = st_ff.mask;
  assign pending_latch      = st_ff.latch;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_gate;
    @(posedge sys_clk) disable iff (!rstn)
      !st_ff.mie |-> !take;
  endproperty
  a_gate: assert property (p_gate) else $error("accept while disabled"); // R4

  property p_mie_clr;
    @(posedge sys_clk) disable iff (!rstn)
      load_pc |-> !master_irq_enable;
  endproperty
  a_mie_clr: assert property (p_mie_clr) else $error("master not cleared"); // R5

  property p_return_from_irq;
    @(posedge sys_clk) disable iff (!rstn)
      (return_from_irq && !ack_busy) |=> (master_irq_enable && restore_ctx);
  endproperty
  a_return_from_irq: assert property (p_return_from_irq) else $error("return failed"); // R16

  property p_seq;
    @(posedge sys_clk) disable iff (!rstn)
      push_ctx |-> !load_pc ##[1:1000] load_pc;
  endproperty
  a_seq: assert property (p_seq) else $error("push not before vector"); // R15

  property p_vec;
    @(posedge sys_clk) disable iff (!rstn)
      load_pc |-> (pc_vector >= 12'h002 && pc_vector <= 12'h00c
                   && pc_vector[0] == 1'b0 && set_status_flag);
  endproperty
  a_vec: assert property (p_vec) else $error("bad vector"); // R3

  property p_prio;
    @(posedge sys_clk) disable iff (!rstn)
      (take && eligible[SRC_EXT_HIGH]) |=> (st_ff.sel == 3'h5);
  endproperty
  a_prio: assert property (p_prio) else $error("priority wrong"); // R2

  property p_hold;
    @(posedge sys_clk) disable iff (!rstn)
      (pending_latch[SRC_TMR1] && !sw_clear && !load_pc && !ack_busy)
        |=> pending_latch[SRC_TMR1];
  endproperty
  a_hold: assert property (p_hold) else $error("latch dropped"); // R13

  property p_win;
    @(posedge sys_clk) disable iff (!rstn)
      (serial_irq && sw_clear && !latch_field[SRC_SERIAL])
        |=> pending_latch[SRC_SERIAL];
  endproperty
  a_win: assert property (p_win) else $error("clear beat request"); // R20

  property p_swap;
    @(posedge sys_clk) disable iff (!rstn)
      swap_with_accumulator |=> (acc_out == $past(source_enable_mask)
                                 && source_enable_mask == $past(acc_in));
  endproperty
  a_swap: assert property (p_swap) else $error("swap wrong"); // R9

  property p_shared;
    @(posedge sys_clk) disable iff (!rstn)
      (!source_enable_mask[1]) |-> !eligible[SRC_TMR2] && !eligible[SRC_TICK];
  endproperty
  a_shared: assert property (p_shared) else $error("shared bit leak"); // R8

  // push only in the first acknowledge cycle
  property p_push_busy;
    @(posedge sys_clk) disable iff (!rstn)
      push_ctx |-> (st_ff.state == PIC_ACK1);
  endproperty
  a_push_busy: assert property (p_push_busy) else $error("stray push"); // R15

  // vector load lands in the second cycle
  property p_load_busy;
    @(posedge sys_clk) disable iff (!rstn)
      load_pc |-> (st_ff.state == PIC_ACK2);
  endproperty
  a_load_busy: assert property (p_load_busy) else $error("stray load"); // R14

  // second cycle end closes acknowledge
  property p_ack_end;
    @(posedge sys_clk) disable iff (!rstn)
      (st_ff.state == PIC_ACK2 && cycle_end) |=> !ack_busy;
  endproperty
  a_ack_end: assert property (p_ack_end) else $error("ack overran"); // R14

  // accepted latch drops unless re-requested
  property p_clr_acc;
    @(posedge sys_clk) disable iff (!rstn)
      (st_ff.state == PIC_ACK1 && cycle_end && !rq.req[st_ff.sel])
        |=> !pending_latch[st_ff.sel];
  endproperty
  a_clr_acc: assert property (p_clr_acc) else $error("latch kept"); // R10

  // software enable sets master outside accept
  property p_sw_set;
    @(posedge sys_clk) disable iff (!rstn)
      (enable_and_clear_latches && !(st_ff.state == PIC_ACK1 && cycle_end))
        |=> master_irq_enable;
  endproperty
  a_sw_set: assert property (p_sw_set) else $error("enable lost"); // R6

  // a latch never rises without its request
  property p_no_set;
    @(posedge sys_clk) disable iff (!rstn)
      (!pending_latch[SRC_SERIAL] && !serial_irq)
        |=> !pending_latch[SRC_SERIAL];
  endproperty
  a_no_set: assert property (p_no_set) else $error("latch set alone"); // R12

  // masked source never eligible
  property p_mask_gate;
    @(posedge sys_clk) disable iff (!rstn)
      !source_enable_mask[MASK_SERIAL] |-> !eligible[SRC_SERIAL];
  endproperty
  a_mask_gate: assert property (p_mask_gate) else $error("mask leak"); // R7
endmodule : pic_ctrl
`default_nettype wire

// File: testbench/pic_seq_model.sv
`timescale 1ns/1ns
`default_nettype none
// sequencer stand-in: paces instruction and cycle ends
module pic_seq_model (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rstn,
  // pacing
  input  wire logic       run,
  input  wire logic [1:0] gap,
  input  wire logic       ack_busy,
  // strobes
  output logic            instr_end,
  output logic            cycle_end
);
  logic [1:0] cnt_ff;

  // cycle ends every gap+1 clocks, instr ends only when idle
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_ff    <= 2'h0;
      instr_end <= 1'b0;
      cycle_end <= 1'b0;
    end else begin
      cnt_ff    <= (cnt_ff >= gap) ? 2'h0 : cnt_ff + 2'h1;
      cycle_end <= (cnt_ff >= gap);
      instr_end <= (cnt_ff >= gap) & run & ~ack_busy;
    end
  end
endmodule : pic_seq_model
`default_nettype wire

// File: testbench/test_prioritized_interrupt_controller.sv
`timescale 1ns/1ns
`default_nettype none
module test_prioritized_interrupt_controller;
  import pic_pkg::*;
  logic        sys_clk, rstn, run, instr_end, cycle_end;
  logic [1:0]  gap, m_st;
  logic        ext_irq_high, ext_irq_low, serial_irq, interval_tick_irq;
  logic        timer_one_overflow_irq, timer_two_overflow_irq;
  logic        enable_and_clear_latches, disable_and_clear_latches;
  logic        clear_latches_only, swap_with_accumulator, return_from_irq;
  logic [5:0]  latch_field, pending_latch, m_lat, lat_n, req, en, pend, p;
  logic [3:0]  acc_in, acc_out, source_enable_mask, m_msk, m_acc;
  logic        irq_pending, ack_busy, push_ctx, restore_ctx, load_pc;
  logic        set_status_flag, master_irq_enable;
  logic [11:0] pc_vector, m_vec;
  logic        m_mie, m_push, m_load, m_rest, m_phi, m_plo;
  logic [31:0] r, q;
  int          err_total, num_checks, seed, i, n, m_sel;

  pic_ctrl dut_u (
    .sys_clk, .rstn, .ext_irq_high, .ext_irq_low, .serial_irq,
    .timer_one_overflow_irq, .timer_two_overflow_irq, .interval_tick_irq,
    .instr_end, .cycle_end, .enable_and_clear_latches,
    .disable_and_clear_latches, .clear_latches_only, .latch_field,
    .swap_with_accumulator, .acc_in, .return_from_irq, .irq_pending,
    .ack_busy, .push_ctx, .restore_ctx, .load_pc, .pc_vector,
    .set_status_flag, .acc_out, .master_irq_enable, .source_enable_mask,
    .pending_latch);
  pic_seq_model seq_u (.sys_clk, .rstn, .run, .gap, .ack_busy, .instr_end,
                       .cycle_end);

  ////////////////////////////////////////////////////////////////////////////
  // mask bit per source, bit 1 shared
  assign en   = {1'b1, m_msk[3:2], m_msk[1], m_msk[1:0]};
  assign pend = m_mie ? (m_lat & en) : 6'h00;

  // reference controller, updated on the same edges
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      {m_lat, m_msk, m_acc, m_vec, m_st, m_mie} = '0;
      {m_push, m_load, m_rest, m_phi, m_plo} = 5'h03;
    end else begin
      p = pend;
      req = {m_phi & ~ext_irq_high, serial_irq, timer_one_overflow_irq,
             timer_two_overflow_irq, interval_tick_irq, m_plo & ~ext_irq_low};
      m_phi = ext_irq_high;
      m_plo = ext_irq_low;
      {m_push, m_load, m_rest} = 3'h0;
      lat_n = m_lat;
      if (enable_and_clear_latches | disable_and_clear_latches |
          clear_latches_only)
        lat_n = lat_n & latch_field;
      if (swap_with_accumulator) begin
        m_acc = m_msk;
        m_msk = acc_in;
      end
      if (enable_and_clear_latches) m_mie = 1'b1;
      else if (disable_and_clear_latches) m_mie = 1'b0;
      if (return_from_irq && m_st == 2'd0) begin
        m_rest = 1'b1;
        m_mie = 1'b1;
      end
      case (m_st)
        2'd0: if (instr_end && !return_from_irq && p != 6'h00) begin
          for (int k = 0; k < 6; k++) begin
            if (p[k]) m_sel = k;
          end
          m_st = 2'd1;
          m_push = 1'b1;
        end
        2'd1: if (cycle_end) begin
          m_st = 2'd2;
          m_load = 1'b1;
          m_vec = VEC_BASE + VEC_STEP * 12'(5 - m_sel);
          m_mie = 1'b0;
          lat_n[m_sel] = 1'b0;
        end
        default: if (cycle_end) m_st = 2'd0;
      endcase
      m_lat = lat_n | req;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // a wait that used up its bound counts as a mismatch
  task automatic lim(input int cnt);
    if (cnt >= 80) begin
      err_total++;
      $display("MISMATCH t=%0t wait got=%h exp=%h", $time, cnt, 0);
    end
  endtask : lim

  task automatic wrap_up();
    $display("checks=%0d errors=%0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : wrap_up

  // one clock of stimulus: pin levels and pulses, ops, field, accumulator
  task automatic cyc(input logic [5:0] s, input logic [4:0] op,
                     input logic [5:0] fld, input logic [3:0] acc);
    @(posedge sys_clk);
    {ext_irq_high, serial_irq, timer_one_overflow_irq, timer_two_overflow_irq,
     interval_tick_irq, ext_irq_low} <= s;
    {enable_and_clear_latches, disable_and_clear_latches, clear_latches_only,
     swap_with_accumulator, return_from_irq} <= op;
    latch_field <= fld;
    acc_in <= acc;
    #1;
  endtask : cyc

  // wait for a vector load, let the acknowledge end, then return
  task automatic serve(input logic [11:0] exp);
    for (n = 0; n < 80 && load_pc !== 1'b1; n++) cyc(6'h21, 5'h0, 6'h3f, 4'h0);
    lim(n);
    chk(pc_vector, exp);
    for (n = 0; n < 80 && ack_busy !== 1'b0; n++) cyc(6'h21, 5'h0, 6'h3f, 4'h0);
    lim(n);
    cyc(6'h21, 5'h01, 6'h3f, 4'h0);
  endtask : serve

  ////////////////////////////////////////////////////////////////////////////
  always @(negedge sys_clk) begin
    chk(12'(pending_latch), 12'(m_lat));
    chk(12'(master_irq_enable), 12'(m_mie));
    chk(12'(source_enable_mask), 12'(m_msk));
    chk(12'(acc_out), 12'(m_acc));
    chk(12'(irq_pending), 12'(pend != 6'h00));
    chk(12'({push_ctx, load_pc, set_status_flag, restore_ctx, ack_busy}),
        12'({m_push, m_load, m_load, m_rest, m_st != 2'd0}));
    chk(pc_vector, m_vec);
  end

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  initial begin
    seed = 32'h7cc94806;
    err_total = 0;
    num_checks = 0;
    rstn = 1'b0;
    run = 1'b0;
    gap = 2'h1;
    {ext_irq_high, ext_irq_low} = 2'h3;
    {serial_irq, timer_one_overflow_irq, timer_two_overflow_irq} = 3'h0;
    {interval_tick_irq, enable_and_clear_latches} = 2'h0;
    {disable_and_clear_latches, clear_latches_only} = 2'h0;
    {swap_with_accumulator, return_from_irq} = 2'h0;
    latch_field = 6'h3f;
    acc_in = 4'h0;
    repeat (6) @(posedge sys_clk);
    rstn <= 1'b1;
    // all six at once, served in priority order
    cyc(6'h21, 5'h02, 6'h3f, 4'hf);
    cyc(6'h1e, 5'h00, 6'h3f, 4'h0);
    cyc(6'h21, 5'h10, 6'h3f, 4'h0);
    run <= 1'b1;
    for (i = 0; i < 6; i++) serve(VEC_BASE + VEC_STEP * 12'(i));
    // master off; request in the same clock as a full clear
    cyc(6'h21, 5'h08, 6'h3f, 4'h0);
    cyc(6'h31, 5'h04, 6'h00, 4'h0);
    repeat (20) cyc(6'h21, 5'h00, 6'h3f, 4'h0);
    // only the shared bit enabled
    cyc(6'h21, 5'h02, 6'h3f, 4'h2);
    cyc(6'h37, 5'h10, 6'h00, 4'h0);
    serve(VEC_BASE + VEC_STEP * 12'h3);
    serve(VEC_BASE + VEC_STEP * 12'h4);
    // random traffic with a reset in mid-run
    for (i = 0; i < 4000; i++) begin
      if (i % 500 == 0) gap <= 2'($random(seed));
      rstn <= !(i >= 2000 && i < 2003);
      r = $random(seed);
      q = $random(seed);
      // service code re-enables and masks at random
      cyc({r[0], &r[3:1], &r[6:4], &r[9:7], &r[12:10], r[13]},
          {&r[17:14], &r[21:18], &r[24:22], &r[27:25], &r[30:28]},
          q[5:0], q[9:6]);
    end
    wrap_up();
  end
endmodule : test_prioritized_interrupt_controller
`default_nettype wire
